// ==== logic/mdr_pkg.sv ====
// Constants, field layouts and register map of the strided descriptor reader
// Operation
// - Stream side carries 5-bit id, 5-bit destination and 4-bit user beside data.
// - No control or status sideband streams; application words never fetched.
// - Word 00h holds next pointer bits 31:6; descriptors sit on 64-byte boundaries.
// - Word 04h gives the upper 32 bits of the next pointer.
// - Word 0Ch gives the upper 32 bits of the buffer address.
// - Control bits 4:0 drive the stream destination, constant for the packet.
// - Control bits 12:8 drive the stream id, constant for the packet.
// - Control bits 19:16 drive the stream user field, constant for the packet.
// - Control bits 31:28 drive the read user attribute; software keeps it equal.
// - Word 14h bits 15:0 give the distance between consecutive line starts.
// - Read line bytes, step to start plus pitch, repeat for all lines.
// - All lines leave as one packet; last is set once, on the final beat.
// - Word 14h bits 31:19 give the number of lines per descriptor.
// - Word 18h bits 15:0 give the bytes read per line.
// - Word 18h bit 26 marks the descriptor whose buffer ends the packet.
// - Word 18h bit 27 marks the descriptor whose buffer starts the packet.
// - A packet may span several descriptors, from start flag to end flag.
// - Channel counts of both paths are build-time choices.
// - Status flags internal, target and decode errors; the engine halts.
package mdr_pkg;
	// Build-time channel counts for both directions
	localparam logic [4:0]  READ_PATH_CHANNELS  = 5'h01;
	localparam logic [4:0]  WRITE_PATH_CHANNELS = 5'h01;
	// Software register byte offsets
	localparam logic [7:0]  REG_CONTROL    = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_CUR_LO     = 8'h08;
	localparam logic [7:0]  REG_CUR_HI     = 8'h0C;
	localparam logic [7:0]  REG_TAIL_LO    = 8'h10;
	localparam logic [7:0]  REG_TAIL_HI    = 8'h14;
	localparam logic [7:0]  REG_CONFIG     = 8'h18;
	// Status register bit positions and the config write-channel field LSB
	localparam int          ST_IDLE        = 0;
	localparam int          ST_HALTED      = 1;
	localparam int          ST_IN_PACKET   = 2;
	localparam int          ST_INT_ERR     = 28;
	localparam int          ST_TGT_ERR     = 29;
	localparam int          ST_DEC_ERR     = 30;
	localparam int          CFG_WR_CH_LSB  = 8;
	// Descriptor word indices and fields
	localparam int          DESC_WORDS     = 8;
	localparam logic [2:0]  DW_NEXT_LO     = 3'h0;
	localparam logic [2:0]  DW_NEXT_HI     = 3'h1;
	localparam logic [2:0]  DW_BUF_LO      = 3'h2;
	localparam logic [2:0]  DW_BUF_HI      = 3'h3;
	localparam logic [2:0]  DW_CONTROL     = 3'h4;
	localparam logic [2:0]  DW_PITCH_LINES = 3'h5;
	localparam logic [2:0]  DW_LINE_BYTES  = 3'h6;
	localparam int          NEXT_PTR_LSB   = 6;
	localparam int          TDEST_LSB      = 0;
	localparam int          TID_LSB        = 8;
	localparam int          TUSER_LSB      = 16;
	localparam int          CACHE_LSB      = 24;
	localparam int          ARUSER_LSB     = 28;
	localparam int          LINES_LSB      = 19;
	localparam int          EOP_BIT        = 26;
	localparam int          SOP_BIT        = 27;
	// Read bus constants
	localparam logic [3:0]  DEF_ARCACHE    = 4'h3;
	localparam logic [2:0]  AR_SIZE_WORD   = 3'h2;
	localparam logic [1:0]  AR_BURST_INCR  = 2'h1;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	localparam logic [1:0]  RESP_DECERR    = 2'h3;
	localparam logic [4:0]  MAX_BURST      = 5'h10;
	localparam logic [10:0] WORDS_PER_4K   = 11'h400;
	localparam logic [7:0]  DESC_ARLEN     = 8'h07;

	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_DESC_AR = 3'b001,
		S_DESC_R  = 3'b010,
		S_LINE_AR = 3'b011,
		S_LINE_R  = 3'b100,
		S_NEXT    = 3'b101,
		S_HALT    = 3'b110
	} mdr_state_t;
endpackage

// ==== logic/mdr_reader.sv ====
// Descriptor-driven strided memory reader feeding one stream master
`timescale 1ns/1ps
`default_nettype none
module mdr_reader (
	input  wire logic          SYS_CLK,
	input  wire logic          RESET,
	// Register port
	input  wire logic [7:0]    REG_ADDR,
	input  wire logic [31:0]   REG_WDATA,
	input  wire logic          REG_WR,
	input  wire logic          REG_RD,
	output logic [31:0]        REG_RDATA,
	// Memory read address channel
	output logic [63:0]        ARADDR,
	output logic [7:0]         ARLEN,
	output logic [2:0]         ARSIZE,
	output logic [1:0]         ARBURST,
	output logic [3:0]         ARCACHE,
	output logic [3:0]         ARUSER,
	output logic               ARVALID,
	input  wire logic          ARREADY,
	// Memory read data channel
	input  wire logic [31:0]   RDATA,
	input  wire logic [1:0]    RRESP,
	input  wire logic          RLAST,
	input  wire logic          RVALID,
	output logic               RREADY,
	// Read path stream master
	output logic [31:0]        TDATA,
	output logic [3:0]         TKEEP,
	output logic               TLAST,
	output logic [4:0]         TID,
	output logic [4:0]         TDEST,
	output logic [3:0]         TUSER,
	output logic               TVALID,
	input  wire logic          TREADY
);
	import mdr_pkg::*;

	mdr_state_t  st_r;
	logic [31:0] desc_r [0:DESC_WORDS-1];
	logic [2:0]  widx_r;
	logic        run_r;
	logic        start_pend_r;
	logic [63:0] cur_r;
	logic [63:0] tail_r;
	logic [2:0]  err_r;
	logic        beat_err_r;
	logic        in_pkt_r;
	logic [63:0] line_base_r;
	logic [63:0] req_addr_r;
	logic [15:0] req_left_r;
	logic [15:0] rcv_left_r;
	logic [12:0] lines_left_r;
	logic        tvalid_r;
	logic [31:0] rdata_r;

	// Ceiling of bytes over the word size
	function automatic logic [14:0] beats_for(input logic [15:0] bytes);
		logic [16:0] s;
		s = {1'b0, bytes} + 17'h00003;
		return s[16:2];
	endfunction

	// Byte lanes holding the bytes still due in this line
	function automatic logic [3:0] keep_for(input logic [15:0] left);
		logic [3:0] k;
		k = 4'hF;
		if (left == 16'h0001)
			k = 4'h1;
		else if (left == 16'h0002)
			k = 4'h3;
		else if (left == 16'h0003)
			k = 4'h7;
		return k;
	endfunction

	// Descriptor fields
	logic [31:0] ctl_w;
	logic [15:0] pitch_w;
	logic [12:0] lines_w;
	logic [15:0] hsize_w;
	logic        eop_w;
	logic        sop_w;
	logic [63:0] next_w;
	logic [63:0] buf_w;
	assign ctl_w   = desc_r[DW_CONTROL];
	assign pitch_w = desc_r[DW_PITCH_LINES][15:0];
	assign lines_w = desc_r[DW_PITCH_LINES][31:LINES_LSB];
	assign hsize_w = desc_r[DW_LINE_BYTES][15:0];
	assign eop_w   = desc_r[DW_LINE_BYTES][EOP_BIT];
	assign sop_w   = desc_r[DW_LINE_BYTES][SOP_BIT];
	// Low six pointer bits are reserved and forced to zero
	assign next_w  = {desc_r[DW_NEXT_HI], desc_r[DW_NEXT_LO][31:NEXT_PTR_LSB], 6'h00};
	assign buf_w   = {desc_r[DW_BUF_HI], desc_r[DW_BUF_LO]};

	// Burst sizing: at most 16 beats, never across a 4 KB boundary
	logic [14:0] need_w;
	logic [10:0] room_w;
	logic [4:0]  burst_w;
	logic [15:0] take_w;
	always_comb begin
		need_w  = beats_for(req_left_r);
		room_w  = WORDS_PER_4K - {1'b0, req_addr_r[11:2]};
		burst_w = MAX_BURST;
		if (need_w < {10'h000, MAX_BURST})
			burst_w = need_w[4:0];
		if (room_w < {6'h00, burst_w})
			burst_w = room_w[4:0];
		take_w = {9'h000, burst_w, 2'b00};
		if (take_w > req_left_r)
			take_w = req_left_r;
	end

	// Handshakes
	logic ar_fire;
	logic r_fire;
	logic line_beat;
	logic out_open;
	assign out_open  = !tvalid_r || TREADY;
	assign RREADY    = (st_r == S_DESC_R) || (st_r == S_LINE_R && out_open);
	assign ARVALID   = (st_r == S_DESC_AR) || (st_r == S_LINE_AR);
	assign ar_fire   = ARVALID && ARREADY;
	assign r_fire    = RVALID && RREADY;
	assign line_beat = r_fire && (st_r == S_LINE_R);

	// Read address channel; descriptor fetch covers words 00h..1Ch only
	always_comb begin
		ARSIZE  = AR_SIZE_WORD;
		ARBURST = AR_BURST_INCR;
		if (st_r == S_DESC_AR) begin
			ARADDR  = cur_r;
			ARLEN   = DESC_ARLEN;
			ARCACHE = DEF_ARCACHE;
			ARUSER  = 4'h0;
		end else begin
			ARADDR  = req_addr_r;
			ARLEN   = {3'h0, burst_w - 5'h01};
			ARCACHE = ctl_w[CACHE_LSB +: 4];
			ARUSER  = ctl_w[ARUSER_LSB +: 4];
		end
	end

	// Descriptor checks made when the fetch completes
	logic bad_desc_w;
	assign bad_desc_w = (lines_w == 13'h0000) || (hsize_w == 16'h0000) || (sop_w == in_pkt_r);

	// Error events from the memory response and descriptor checks
	logic tgt_set;
	logic dec_set;
	logic int_set;
	logic desc_end;
	assign tgt_set  = r_fire && (RRESP == RESP_SLVERR);
	assign dec_set  = r_fire && (RRESP == RESP_DECERR);
	assign desc_end = (st_r == S_DESC_R) && r_fire && RLAST;
	assign int_set  = desc_end && !beat_err_r && !tgt_set && !dec_set && bad_desc_w;

	// Last byte of the final line of the end descriptor
	logic line_done;
	logic final_beat;
	assign line_done  = rcv_left_r <= 16'h0004;
	assign final_beat = eop_w && (lines_left_r == 13'h0001) && line_done;

	// Main sequencer
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			st_r <= S_IDLE;
		end else begin
			case (st_r)
				S_IDLE: begin
					if (run_r && start_pend_r && err_r == 3'b000)
						st_r <= S_DESC_AR;
				end
				S_DESC_AR: begin
					if (ar_fire)
						st_r <= S_DESC_R;
				end
				S_DESC_R: begin
					// Beats keep being drained after an error so the bus stays clean
					if (desc_end)
						st_r <= (beat_err_r || tgt_set || dec_set || bad_desc_w) ? S_HALT : S_LINE_AR;
				end
				S_LINE_AR: begin
					if (ar_fire)
						st_r <= S_LINE_R;
				end
				S_LINE_R: begin
					if (line_beat && RLAST) begin
						if (beat_err_r || tgt_set || dec_set)
							st_r <= S_HALT;
						else if (req_left_r != 16'h0000 || lines_left_r != 13'h0001)
							st_r <= S_LINE_AR;
						else
							st_r <= S_NEXT;
					end
				end
				S_NEXT: begin
					st_r <= (cur_r == tail_r || !run_r) ? S_IDLE : S_DESC_AR;
				end
				S_HALT: begin
					if (err_r == 3'b000)
						st_r <= S_IDLE;
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// Descriptor word capture
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			widx_r <= 3'h0;
			for (int i = 0; i < DESC_WORDS; i++)
				desc_r[i] <= 32'h0000_0000;
		end else if (st_r == S_DESC_AR) begin
			widx_r <= 3'h0;
		end else if (st_r == S_DESC_R && r_fire) begin
			desc_r[widx_r] <= RDATA;
			widx_r         <= widx_r + 3'h1;
		end
	end

	// Error seen inside the current burst
	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			beat_err_r <= 1'b0;
		else if (ar_fire)
			beat_err_r <= 1'b0;
		else if (tgt_set || dec_set)
			beat_err_r <= 1'b1;
	end

	// Line walk: each new line starts one pitch after the last one
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			line_base_r  <= 64'h0;
			req_addr_r   <= 64'h0;
			req_left_r   <= 16'h0000;
			rcv_left_r   <= 16'h0000;
			lines_left_r <= 13'h0000;
		end else if (st_r == S_DESC_R) begin
			// Descriptor words settle in the array before S_LINE_AR reads them
			line_base_r  <= buf_w;
			req_addr_r   <= buf_w;
			req_left_r   <= hsize_w;
			rcv_left_r   <= hsize_w;
			lines_left_r <= lines_w;
		end else if (st_r == S_LINE_AR && ar_fire) begin
			req_addr_r <= req_addr_r + {57'h0, burst_w, 2'b00};
			req_left_r <= req_left_r - take_w;
		end else if (line_beat) begin
			rcv_left_r <= line_done ? 16'h0000 : rcv_left_r - 16'h0004;
			if (RLAST && req_left_r == 16'h0000 && lines_left_r != 13'h0001) begin
				line_base_r  <= line_base_r + {48'h0, pitch_w};
				req_addr_r   <= line_base_r + {48'h0, pitch_w};
				req_left_r   <= hsize_w;
				rcv_left_r   <= hsize_w;
				lines_left_r <= lines_left_r - 13'h0001;
			end
		end
	end

	// Packet framing across chained descriptors
	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			in_pkt_r <= 1'b0;
		else if (desc_end && sop_w && !bad_desc_w)
			in_pkt_r <= 1'b1;
		else if (st_r == S_NEXT && eop_w)
			in_pkt_r <= 1'b0;
		else if (st_r == S_HALT)
			in_pkt_r <= 1'b0;
	end

	// Sideband latched from the start descriptor only, so the packet keeps it
	logic [4:0] sb_dest_r;
	logic [4:0] sb_id_r;
	logic [3:0] sb_user_r;
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			sb_dest_r <= 5'h00;
			sb_id_r   <= 5'h00;
			sb_user_r <= 4'h0;
		end else if (desc_end && sop_w && !bad_desc_w) begin
			// Control word is already captured when the last descriptor beat lands
			sb_dest_r <= ctl_w[TDEST_LSB +: 5];
			sb_id_r   <= ctl_w[TID_LSB +: 5];
			sb_user_r <= ctl_w[TUSER_LSB +: 4];
		end
	end

	// Output stage: one register slice between memory and stream
	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			tvalid_r <= 1'b0;
		else if (line_beat)
			tvalid_r <= 1'b1;
		else if (TREADY)
			tvalid_r <= 1'b0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			TDATA <= 32'h0000_0000;
			TKEEP <= 4'h0;
			TLAST <= 1'b0;
			TID   <= 5'h00;
			TDEST <= 5'h00;
			TUSER <= 4'h0;
		end else if (line_beat) begin
			TDATA <= RDATA;
			TKEEP <= keep_for(rcv_left_r);
			TLAST <= final_beat;
			// Sideband comes from the start descriptor for every beat
			TDEST <= sb_dest_r;
			TID   <= sb_id_r;
			TUSER <= sb_user_r;
		end
	end
	assign TVALID = tvalid_r;

	// Run control and start request; a tail write that meets the start wins
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			run_r        <= 1'b0;
			start_pend_r <= 1'b0;
		end else begin
			if (REG_WR && REG_ADDR == REG_CONTROL)
				run_r <= REG_WDATA[0];
			if (REG_WR && REG_ADDR == REG_TAIL_LO)
				start_pend_r <= 1'b1;
			else if (st_r == S_IDLE && run_r && err_r == 3'b000)
				start_pend_r <= 1'b0;
		end
	end

	// Descriptor pointers; hardware walks the current pointer along the chain
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			cur_r  <= 64'h0;
			tail_r <= 64'h0;
		end else begin
			if (st_r == S_NEXT)
				cur_r <= next_w;
			else if (REG_WR && REG_ADDR == REG_CUR_LO && st_r == S_IDLE)
				cur_r[31:0] <= {REG_WDATA[31:NEXT_PTR_LSB], 6'h00};
			else if (REG_WR && REG_ADDR == REG_CUR_HI && st_r == S_IDLE)
				cur_r[63:32] <= REG_WDATA;
			if (REG_WR && REG_ADDR == REG_TAIL_LO)
				tail_r[31:0] <= {REG_WDATA[31:NEXT_PTR_LSB], 6'h00};
			if (REG_WR && REG_ADDR == REG_TAIL_HI)
				tail_r[63:32] <= REG_WDATA;
		end
	end

	// Error flags: write one to clear, a new event in the same cycle wins
	logic [2:0] err_set;
	logic [2:0] err_clr;
	assign err_set = {dec_set, tgt_set, int_set};
	assign err_clr = (REG_WR && REG_ADDR == REG_STATUS) ? REG_WDATA[ST_DEC_ERR:ST_INT_ERR] : 3'b000;
	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			err_r <= 3'b000;
		else
			err_r <= (err_r & ~err_clr) | err_set;
	end

	// Read data live only in the cycle after the strobe
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (REG_ADDR)
			REG_CONTROL: rd_mux[0] = run_r;
			REG_STATUS: begin
				rd_mux[ST_IDLE]                = (st_r == S_IDLE);
				rd_mux[ST_HALTED]              = (st_r == S_HALT);
				rd_mux[ST_IN_PACKET]           = in_pkt_r;
				rd_mux[ST_DEC_ERR:ST_INT_ERR]  = err_r;
			end
			REG_CUR_LO:  rd_mux = cur_r[31:0];
			REG_CUR_HI:  rd_mux = cur_r[63:32];
			REG_TAIL_LO: rd_mux = tail_r[31:0];
			REG_TAIL_HI: rd_mux = tail_r[63:32];
			REG_CONFIG:  rd_mux = {19'h0, WRITE_PATH_CHANNELS, 3'h0, READ_PATH_CHANNELS};
			default:     rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			rdata_r <= 32'h0000_0000;
		else
			rdata_r <= REG_RD ? rd_mux : 32'h0000_0000;
	end
	assign REG_RDATA = rdata_r;

	// Checker helpers: sideband of the first beat of each packet
	logic       mid_pkt_r;
	logic [4:0] first_dest_r;
	logic [4:0] first_id_r;
	logic [3:0] first_user_r;
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			mid_pkt_r    <= 1'b0;
			first_dest_r <= 5'h00;
			first_id_r   <= 5'h00;
			first_user_r <= 4'h0;
		end else if (TVALID && TREADY) begin
			mid_pkt_r <= !TLAST;
			if (!mid_pkt_r) begin
				first_dest_r <= TDEST;
				first_id_r   <= TID;
				first_user_r <= TUSER;
			end
		end
	end

	dest_stable_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		TVALID && mid_pkt_r |-> TDEST == first_dest_r)
		else $error("destination changed inside a packet");
	id_stable_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		TVALID && mid_pkt_r |-> TID == first_id_r)
		else $error("stream id changed inside a packet");
	user_stable_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		TVALID && mid_pkt_r |-> TUSER == first_user_r)
		else $error("user field changed inside a packet");
	cache_attr_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		st_r == S_LINE_AR && ARVALID |-> ARCACHE == desc_r[DW_CONTROL][27:24])
		else $error("cache attribute not from control word");
	user_attr_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		st_r == S_LINE_AR && ARVALID |-> ARUSER == desc_r[DW_CONTROL][31:28])
		else $error("read user attribute not from control word");
	desc_align_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		st_r == S_DESC_AR && ARVALID |-> ARADDR[5:0] == 6'h00)
		else $error("descriptor fetch not 64-byte aligned");
	desc_len_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		st_r == S_DESC_AR && ARVALID |-> ARLEN == 8'h07)
		else $error("descriptor fetch reads application words");
	line_step_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		line_beat && RLAST && !beat_err_r && RRESP[1] == 1'b0 && req_left_r == 16'h0000
		&& lines_left_r != 13'h0001
		|=> st_r == S_LINE_AR && req_addr_r == $past(line_base_r) + {48'h0, pitch_w})
		else $error("next line does not start one pitch later");
	last_beat_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		line_beat && RLAST && RRESP[1] == 1'b0 && !beat_err_r && req_left_r == 16'h0000
		&& lines_left_r == 13'h0001 |=> TVALID && (TLAST == eop_w) ##1 st_r == S_IDLE || st_r == S_DESC_AR)
		else $error("end of descriptor framing wrong");
	err_halt_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
		r_fire && RLAST && RRESP == RESP_SLVERR |=> st_r == S_HALT && err_r[1])
		else $error("target error did not halt the engine");
endmodule
`default_nettype wire

// ==== tb/mdr_mem_model.sv ====
// Behavioural memory answering one read burst at a time with random stalls
`timescale 1ns/1ps
`default_nettype none
module mdr_mem_model
	import mdr_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RESET,
	input  wire logic [63:0] ARADDR,
	input  wire logic [7:0]  ARLEN,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RLAST,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic [1:0]  err_resp
);
	logic [31:0] mem [0:4095];
	logic [11:0] a_r;
	logic [7:0]  n_r;
	logic        busy_r;

	// One burst at a time; idle data lines toggle so stale values never look valid
	always @(posedge SYS_CLK) begin
		if (RESET) begin
			busy_r  <= 1'b0;
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RLAST   <= 1'b0;
			RRESP   <= 2'h0;
			RDATA   <= 32'h0;
		end else if (!busy_r) begin
			RDATA   <= ~RDATA;
			if (ARVALID && ARREADY) begin
				busy_r  <= 1'b1;
				ARREADY <= 1'b0;
				a_r     <= ARADDR[13:2];
				n_r     <= ARLEN;
			end else begin
				ARREADY <= ($urandom % 2) != 0;
			end
		end else if (RVALID && !RREADY) begin
			RVALID <= 1'b1; // Beat held until taken
		end else if (RVALID && RLAST) begin
			RVALID <= 1'b0;
			busy_r <= 1'b0;
			RDATA  <= ~RDATA;
			RLAST  <= 1'b0;
		end else if (($urandom % 3) != 0) begin
			RVALID <= 1'b1;
			RDATA  <= mem[a_r];
			RLAST  <= (n_r == 8'h00);
			RRESP  <= err_resp;
			a_r    <= a_r + 12'h001;
			n_r    <= n_r - 8'h01;
		end else begin
			RVALID <= 1'b0;
			RDATA  <= ~RDATA;
			RLAST  <= ~RLAST;
		end
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench: descriptor chains in memory, stream compared byte by byte
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mdr_pkg::*;
	logic SYS_CLK, RESET, REG_WR, REG_RD, TREADY, ARREADY, RLAST, RVALID, RREADY, ARVALID;
	logic TLAST, TVALID;
	logic [7:0] REG_ADDR, ARLEN;
	logic [31:0] REG_WDATA, REG_RDATA, RDATA, TDATA, rd, ctl;
	logic [63:0] ARADDR;
	logic [2:0] ARSIZE;
	logic [1:0] ARBURST, RRESP, err_resp;
	logic [3:0] ARCACHE, ARUSER, TKEEP, TUSER;
	logic [4:0] TID, TDEST;
	logic [7:0] exp_q[$], got_q[$];
	int miscompares = 0, checked = 0, lasts, last_pos, hs, ln, pt, bit_no;
	logic mon_on;

	mdr_reader u_mdr_reader (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ARADDR(ARADDR), .ARLEN(ARLEN),
		.ARSIZE(ARSIZE), .ARBURST(ARBURST), .ARCACHE(ARCACHE), .ARUSER(ARUSER), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RLAST(RLAST), .RVALID(RVALID), .RREADY(RREADY),
		.TDATA(TDATA), .TKEEP(TKEEP), .TLAST(TLAST), .TID(TID), .TDEST(TDEST), .TUSER(TUSER),
		.TVALID(TVALID), .TREADY(TREADY));
	mdr_mem_model u_mdr_mem_model (.SYS_CLK(SYS_CLK), .RESET(RESET), .ARADDR(ARADDR), .ARLEN(ARLEN),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RLAST(RLAST),
		.RVALID(RVALID), .RREADY(RREADY), .err_resp(err_resp));

	initial begin
		SYS_CLK = 1'b0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end

	task automatic check(string name, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic reg_wr(logic [7:0] a, logic [31:0] d);
		@(posedge SYS_CLK);
		REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask

	task automatic reg_rd(logic [7:0] a);
		@(posedge SYS_CLK);
		REG_RD <= 1'b1; REG_ADDR <= a;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1 rd = REG_RDATA;
	endtask

	// Descriptor image in memory plus the bytes the stream must carry for it
	task automatic put_desc(int a, int nxt, int bufa, int pitch, int lines, int hsz, int flags);
		u_mdr_mem_model.mem[a/4] = nxt;
		u_mdr_mem_model.mem[a/4+1] = 32'h0;
		u_mdr_mem_model.mem[a/4+2] = bufa;
		u_mdr_mem_model.mem[a/4+3] = 32'h0;
		u_mdr_mem_model.mem[a/4+4] = ctl;
		u_mdr_mem_model.mem[a/4+5] = (lines << LINES_LSB) | pitch;
		u_mdr_mem_model.mem[a/4+6] = (flags << EOP_BIT) | hsz;
		u_mdr_mem_model.mem[a/4+7] = 32'h0;
		for (int l = 0; l < lines; l++)
			for (int b = 0; b < hsz; b++)
				exp_q.push_back(u_mdr_mem_model.mem[(bufa+l*pitch+b)/4][8*((bufa+l*pitch+b)%4)+:8]);
	endtask

	task automatic run(int first, int last);
		reg_wr(REG_CUR_LO, first);
		reg_wr(REG_CUR_HI, 32'h0);
		reg_wr(REG_TAIL_HI, 32'h0);
		reg_wr(REG_CONTROL, 32'h1);
		reg_wr(REG_TAIL_LO, last);
	endtask

	task automatic finish_packet();
		for (int i = 0; i < 20000 && lasts == 0; i++) @(posedge SYS_CLK);
		repeat (4) @(posedge SYS_CLK);
		check("tlast_count", 1, lasts);
		check("tlast_pos", exp_q.size(), last_pos);
		check("byte_count", exp_q.size(), got_q.size());
		for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) check("byte", exp_q[i], got_q[i]);
		reg_rd(REG_STATUS);
		check("idle_after", 32'h1, rd & 32'h7);
		exp_q = {}; got_q = {}; lasts = 0;
	endtask

	// Stream sink with random back-pressure; sideband tied to the start descriptor
	always @(posedge SYS_CLK) begin
		TREADY <= ($urandom % 4) != 0;
		if (mon_on && TVALID && TREADY) begin
			for (int b = 0; b < 4; b++) if (TKEEP[b]) got_q.push_back(TDATA[8*b+:8]);
			check("tdest", ctl[4:0], TDEST);
			check("tid", ctl[12:8], TID);
			check("tuser", ctl[19:16], TUSER);
			if (TLAST) begin lasts++; last_pos = got_q.size(); end
		end
		if (mon_on && ARVALID && ARREADY) begin
			check("arsize", AR_SIZE_WORD, ARSIZE);
			check("arburst", AR_BURST_INCR, ARBURST);
		end
		if (mon_on && ARVALID && ARREADY && ARADDR >= 64'h1000) begin
			check("arcache", ctl[27:24], ARCACHE);
			check("aruser", ctl[31:28], ARUSER);
		end
	end

	initial begin
		#(25.0 * 90000);
		miscompares++;
		close_out();
	end

	initial begin
		RESET = 1'b1; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 8'h00; REG_WDATA = 32'h0;
		TREADY = 1'b0; err_resp = 2'h0; mon_on = 1'b1; lasts = 0; ctl = 32'h0;
		void'($urandom(17089));
		for (int i = 0; i < 4096; i++) u_mdr_mem_model.mem[i] = $urandom;
		repeat (3) @(posedge SYS_CLK);
		RESET <= 1'b0;
		reg_rd(REG_STATUS);
		check("status_reset", 32'h1, rd);
		reg_rd(REG_CONFIG);
		check("config", {19'h0, WRITE_PATH_CHANNELS, 3'h0, READ_PATH_CHANNELS}, rd);
		reg_rd(8'h40);
		check("unmapped", 32'h0, rd);
		// Two descriptors, one packet; six-byte line length gives partial last beats
		ctl = 32'h3F1A_1F15 & 32'hFF0F_1F1F;
		put_desc('h000, 'h040, 'h1000, 16, 3, 6, 2);
		put_desc('h040, 'h080, 'h1100, 32, 2, 8, 1);
		run('h000, 'h040);
		finish_packet();
		// Random single-descriptor packets with random sideband and geometry
		for (int k = 0; k < 4; k++) begin
			ctl = $urandom & 32'hFF0F_1F1F;
			hs = 1 + $urandom % 40;
			ln = 1 + $urandom % 3;
			pt = ((hs + 3) & ~3) + 4 * ($urandom % 3);
			put_desc('h0C0, 'h100, 'h2000 + 256 * k, pt, ln, hs, 3);
			run('h0C0, 'h0C0);
			finish_packet();
		end
		// Target error, decode error and zero line count each halt the engine
		mon_on = 1'b0;
		for (int k = 0; k < 3; k++) begin
			err_resp = (k == 0) ? RESP_SLVERR : (k == 1) ? RESP_DECERR : 2'h0;
			bit_no = (k == 0) ? ST_TGT_ERR : (k == 1) ? ST_DEC_ERR : ST_INT_ERR;
			put_desc('h140, 'h180, 'h3000, 16, (k == 2) ? 0 : 1, 8, 3);
			exp_q = {};
			run('h140, 'h140);
			rd = 32'h0;
			for (int i = 0; i < 200 && rd[ST_HALTED] !== 1'b1; i++) reg_rd(REG_STATUS);
			check("halted", 32'h2 | (32'h1 << bit_no), rd & 32'h7000_0003);
			err_resp = 2'h0;
			repeat (20) @(posedge SYS_CLK);
			reg_wr(REG_STATUS, 32'h1 << bit_no);
			reg_rd(REG_STATUS);
			check("cleared", 32'h1, rd & 32'h7000_0003);
		end
		got_q = {};
		close_out();
	end
endmodule
`default_nettype wire
